// ==== src/icc_consts.vh ====
/*
 * Constants for the interleave correction control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz sample-side clock.
 */
`ifndef ICC_CONSTS_VH
`define ICC_CONSTS_VH

`define ICC_ADDR_POWER_MODE      8'h25
`define ICC_ADDR_C1_OFS_COARSE   8'h26
`define ICC_ADDR_C1_OFS_FINE     8'h27
`define ICC_ADDR_C1_GAIN_COARSE  8'h28
`define ICC_ADDR_C1_GAIN_MEDIUM  8'h29
`define ICC_ADDR_C1_GAIN_FINE    8'h2A
`define ICC_ADDR_STATUS          8'h30
`define ICC_ADDR_CONTROL         8'h31
`define ICC_ADDR_STATIC_CONTROL  8'h32
`define ICC_ADDR_POWER_DOWN      8'h4A
`define ICC_ADDR_RMS_THR_LOW     8'h50
`define ICC_ADDR_RMS_THR_HIGH    8'h51
`define ICC_ADDR_RMS_HYST        8'h52

`define ICC_MODE_PIN             3'h0
`define ICC_MODE_NORMAL          3'h1
`define ICC_MODE_NAP             3'h2
`define ICC_MODE_SLEEP           3'h4

`define ICC_PIN_NORMAL           2'h0
`define ICC_PIN_NAP              2'h1
`define ICC_PIN_SLEEP            2'h2

`define ICC_CTL_ON               0
`define ICC_CTL_FREEZE           1
`define ICC_CTL_DIS_OFS          2
`define ICC_CTL_DIS_GAIN         3
`define ICC_CTL_DIS_SKEW         4
`define ICC_CTL_NOTCH            5
`define ICC_STATIC_SKIP_COARSE   5
`define ICC_STATIC_WR_MASK       8'h61
`define ICC_PD_ALGO              0
`define ICC_PD_NOTCH             1

`define ICC_RMS_THR_RESET        16'h1000
`define ICC_RESET_ZERO           8'h00

`define ICC_CLK_MHZ              100
`define ICC_METER_PERIOD_NS      1000
`define ICC_METER_CYCLES         ((`ICC_METER_PERIOD_NS * `ICC_CLK_MHZ) / 1000)
`define ICC_SETTLE_MS            1000
`define ICC_SETTLE_CYCLES        (`ICC_SETTLE_MS * 1000 * `ICC_CLK_MHZ)

`endif

// ==== src/icc_ctrl.v ====
/*
 * Control and status logic for a two-core interleaved converter: power mode
 * select, core 1 trims, correction engine control and the RMS power meter.
 * Assumes a serial port front end that delivers one-cycle byte read/write
 * strobes with an 8-bit address, all synchronous to clk.
 */
// Notes on behaviour
// - Mode field: pin, normal, nap, sleep
// - Port disabled until pin seen normal
// - Soft reset keeps power mode register
// - Core 1 offset trims: 8-bit two's complement
// - Trims reset to calibration; host read-modify-writes
// - Gain trim: 4-bit coarse, 8-bit medium, fine
// - Status bit 0: low power freeze
// - Status bit 1: low AC power, no skew updates
// - Status bit 2: settling complete
// - Poor input puts engine in Hold
// - Control bit 0 turns engine on
// - Control bit 1 freezes, resumes in place
// - Control bits 2-4 disable individual adjustments
// - Control bit 5 selects notch filter
// - Static bit 5 skips coarse adjustment
// - Only non-reference core gain adjusted
// - Power down: algorithm bit 0, notch bit 1
// - Square upper 12 bits, average, ~1us compare
// - Threshold at bits 19:4, default 0x1000
// - RMS freeze stops gain and skew estimates and all adjustments
// - Leave Hold at threshold plus hysteresis
// - AC freeze stops skew estimate and skew adjustment only
`timescale 1ns/1ps
`default_nettype none
`include "icc_consts.vh"

module icc_ctrl #(
	parameter integer SAMPLE_W       = 14,
	parameter integer METER_CYCLES   = `ICC_METER_CYCLES,
	parameter integer SETTLE_CYCLES  = `ICC_SETTLE_CYCLES
) (
	input  wire                clk,
	input  wire                reset_n,
	input  wire                soft_reset,
	input  wire [1:0]          sleep_select_pin,
	input  wire                reg_wr,
	input  wire                reg_rd,
	input  wire [7:0]          reg_addr,
	input  wire [7:0]          reg_wdata,
	output reg  [7:0]          reg_rdata,
	output wire                port_enabled,
	input  wire [SAMPLE_W-1:0] sample,
	input  wire                sample_valid,
	input  wire                low_ac_power,
	input  wire [7:0]          cal_ofs_coarse,
	input  wire [7:0]          cal_ofs_fine,
	input  wire [3:0]          cal_gain_coarse,
	input  wire [7:0]          cal_gain_medium,
	input  wire [7:0]          cal_gain_fine,
	input  wire                cal_done,
	output wire [2:0]          power_state,
	output wire [7:0]          trim_ofs_coarse,
	output wire [7:0]          trim_ofs_fine,
	output wire [3:0]          trim_gain_coarse,
	output wire [7:0]          trim_gain_medium,
	output wire [7:0]          trim_gain_fine,
	output wire                engine_run,
	output wire                est_offset_en,
	output wire                est_gain_en,
	output wire                est_skew_en,
	output wire                adj_offset_en,
	output wire                adj_gain_en,
	output wire                adj_skew_en,
	output wire                notch_select,
	output wire                notch_power_down,
	output wire                skip_coarse,
	output wire                engine_starting
);

	localparam [1:0] ST_OFF   = 2'h0;
	localparam [1:0] ST_TRACK = 2'h1;
	localparam [1:0] ST_HOLD  = 2'h2;
	localparam [1:0] ST_FROZE = 2'h3;

	reg  [2:0]  mode_q;
	reg         seen_normal_q;
	reg  [7:0]  ofs_coarse_q;
	reg  [7:0]  ofs_fine_q;
	reg  [3:0]  gain_coarse_q;
	reg  [7:0]  gain_medium_q;
	reg  [7:0]  gain_fine_q;
	reg         trims_loaded_q;
	reg  [7:0]  ctl_q;
	reg  [7:0]  static_q;
	reg  [1:0]  pd_q;
	reg  [15:0] thr_q;
	reg  [7:0]  hyst_q;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         on_prev_q;
	reg         start_q;
	reg  [31:0] settle_cnt_q;
	reg         settled_q;
	reg  [15:0] meter_cnt_q;
	reg  [39:0] acc_q;
	reg  [15:0] nsamp_q;
	reg         low_rms_q;
	reg  [2:0]  power_d;

	wire        wr_ok;
	wire [11:0] top12;
	wire [23:0] square;
	wire [23:0] threshold;
	wire [23:0] hysteresis;
	wire [24:0] release_level;
	wire [39:0] avg;
	wire        meter_tick;
	wire        pd_algo;
	wire        rd_ok;
	wire        settle_last;
	wire [7:0]  status_byte;

	function wr_hit;
		input [7:0] addr;
		begin
			wr_hit = wr_ok && (reg_addr == addr);
		end
	endfunction

	// Port stays shut until the pin first shows normal; afterwards register writes open up
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seen_normal_q <= 1'b0;
		end else if (sleep_select_pin == `ICC_PIN_NORMAL) begin
			seen_normal_q <= 1'b1;
		end
	end
	assign port_enabled = seen_normal_q;
	assign wr_ok        = reg_wr && seen_normal_q;
	// Reads are refused too while the port is shut
	assign rd_ok        = reg_rd && seen_normal_q;

	// Mode register ignores soft reset
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= `ICC_MODE_PIN;
		end else if (wr_hit(`ICC_ADDR_POWER_MODE)) begin
			mode_q <= reg_wdata[2:0];
		end
	end

	// Register override first; code 000 and unlisted codes hand over to the pin
	always @* begin
		case (mode_q)
			`ICC_MODE_NORMAL: power_d = `ICC_MODE_NORMAL;
			`ICC_MODE_NAP:    power_d = `ICC_MODE_NAP;
			`ICC_MODE_SLEEP:  power_d = `ICC_MODE_SLEEP;
			default: begin
				case (sleep_select_pin)
					`ICC_PIN_NAP:   power_d = `ICC_MODE_NAP;
					`ICC_PIN_SLEEP: power_d = `ICC_MODE_SLEEP;
					default:        power_d = `ICC_MODE_NORMAL;
				endcase
			end
		endcase
	end
	assign power_state = power_d;

	// Trims load once from calibration, then follow host writes
	// Soft reset reloads the calibration results, as after power-up
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ofs_coarse_q   <= `ICC_RESET_ZERO;
			ofs_fine_q     <= `ICC_RESET_ZERO;
			gain_coarse_q  <= 4'h0;
			gain_medium_q  <= `ICC_RESET_ZERO;
			gain_fine_q    <= `ICC_RESET_ZERO;
			trims_loaded_q <= 1'b0;
		end else if (cal_done && (!trims_loaded_q || soft_reset)) begin
			ofs_coarse_q   <= cal_ofs_coarse;
			ofs_fine_q     <= cal_ofs_fine;
			gain_coarse_q  <= cal_gain_coarse;
			gain_medium_q  <= cal_gain_medium;
			gain_fine_q    <= cal_gain_fine;
			trims_loaded_q <= 1'b1;
		end else begin
			if (wr_hit(`ICC_ADDR_C1_OFS_COARSE))
				ofs_coarse_q <= reg_wdata;
			if (wr_hit(`ICC_ADDR_C1_OFS_FINE))
				ofs_fine_q <= reg_wdata;
			if (wr_hit(`ICC_ADDR_C1_GAIN_COARSE))
				gain_coarse_q <= reg_wdata[3:0];
			if (wr_hit(`ICC_ADDR_C1_GAIN_MEDIUM))
				gain_medium_q <= reg_wdata;
			if (wr_hit(`ICC_ADDR_C1_GAIN_FINE))
				gain_fine_q <= reg_wdata;
		end
	end
	assign trim_ofs_coarse  = ofs_coarse_q;
	assign trim_ofs_fine    = ofs_fine_q;
	assign trim_gain_coarse = gain_coarse_q;
	assign trim_gain_medium = gain_medium_q;
	assign trim_gain_fine   = gain_fine_q;

	// Engine control registers; soft reset returns them to defaults
	// Static bits are only used at turn-on, so the host writes them first
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q    <= `ICC_RESET_ZERO;
			static_q <= `ICC_RESET_ZERO;
			pd_q     <= 2'h0;
			thr_q    <= `ICC_RMS_THR_RESET;
			hyst_q   <= `ICC_RESET_ZERO;
		end else if (soft_reset) begin
			ctl_q    <= `ICC_RESET_ZERO;
			static_q <= `ICC_RESET_ZERO;
			pd_q     <= 2'h0;
			thr_q    <= `ICC_RMS_THR_RESET;
			hyst_q   <= `ICC_RESET_ZERO;
		end else begin
			if (wr_hit(`ICC_ADDR_CONTROL))
				ctl_q <= reg_wdata;
			if (wr_hit(`ICC_ADDR_STATIC_CONTROL))
				static_q <= reg_wdata & `ICC_STATIC_WR_MASK;
			if (wr_hit(`ICC_ADDR_POWER_DOWN))
				pd_q <= reg_wdata[1:0];
			if (wr_hit(`ICC_ADDR_RMS_THR_LOW))
				thr_q[7:0] <= reg_wdata;
			if (wr_hit(`ICC_ADDR_RMS_THR_HIGH))
				thr_q[15:8] <= reg_wdata;
			if (wr_hit(`ICC_ADDR_RMS_HYST))
				hyst_q <= reg_wdata;
		end
	end

	assign pd_algo          = pd_q[`ICC_PD_ALGO];
	assign notch_power_down = pd_q[`ICC_PD_NOTCH];
	assign notch_select     = ctl_q[`ICC_CTL_NOTCH];

	// RMS meter: square the top 12 bits and average over one compare window
	assign top12      = sample[SAMPLE_W-1 -: 12];
	assign square     = top12 * top12;
	assign threshold  = {4'h0, thr_q, 4'h0};
	assign hysteresis = {12'h000, hyst_q, 4'h0};
	assign release_level = {1'b0, threshold} + {1'b0, hysteresis};
	assign meter_tick = (meter_cnt_q == METER_CYCLES[15:0] - 16'h0001);
	// The number of samples per window is not fixed, so the mean needs a divide
	assign avg        = (nsamp_q == 16'h0000) ? 40'h0 : acc_q / {24'h0, nsamp_q};

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meter_cnt_q <= 16'h0000;
			acc_q       <= 40'h0;
			nsamp_q     <= 16'h0000;
			low_rms_q   <= 1'b0;
		end else if (meter_tick) begin
			meter_cnt_q <= 16'h0000;
			acc_q       <= 40'h0;
			nsamp_q     <= 16'h0000;
			// An empty window leaves the decision as it was
			if (nsamp_q != 16'h0000) begin
				// Between threshold and release level the last decision stands
				if (avg < {16'h0, threshold})
					low_rms_q <= 1'b1;
				else if (avg >= {15'h0, release_level})
					low_rms_q <= 1'b0;
			end
		end else begin
			meter_cnt_q <= meter_cnt_q + 16'h0001;
			if (sample_valid) begin
				acc_q   <= acc_q + {16'h0, square};
				nsamp_q <= nsamp_q + 16'h0001;
			end
		end
	end

	// Engine state: off, tracking, holding on poor input, frozen by host
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (ctl_q[`ICC_CTL_ON] && !pd_algo)
					state_d = ST_TRACK;
			end
			ST_TRACK, ST_HOLD: begin
				if (ctl_q[`ICC_CTL_FREEZE])
					state_d = ST_FROZE;
				else if (low_rms_q)
					state_d = ST_HOLD;
				else
					state_d = ST_TRACK;
			end
			ST_FROZE: begin
				if (!ctl_q[`ICC_CTL_FREEZE])
					state_d = low_rms_q ? ST_HOLD : ST_TRACK;
			end
			default: state_d = ST_OFF;
		endcase
		if (!ctl_q[`ICC_CTL_ON] || pd_algo)
			state_d = ST_OFF;
	end

	// Settling counts Track cycles only; a host freeze keeps the count
	assign settle_last = (settle_cnt_q == SETTLE_CYCLES[31:0] - 32'h1);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q      <= ST_OFF;
			on_prev_q    <= 1'b0;
			start_q      <= 1'b0;
			settle_cnt_q <= 32'h0;
			settled_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			on_prev_q <= (state_q != ST_OFF);
			start_q   <= (state_q != ST_OFF) && !on_prev_q;
			if (state_q == ST_OFF) begin
				settle_cnt_q <= 32'h0;
				settled_q    <= 1'b0;
			end else if (state_q == ST_TRACK && !settled_q) begin
				if (settle_last)
					settled_q <= 1'b1;
				else
					settle_cnt_q <= settle_cnt_q + 32'h1;
			end
		end
	end

	assign engine_run      = (state_q == ST_TRACK) || (state_q == ST_HOLD);
	// One-cycle pulse in the cycle after the engine leaves OFF, marking the coarse pass
	assign engine_starting = start_q;
	assign skip_coarse     = static_q[`ICC_STATIC_SKIP_COARSE];

	// Offset keeps estimating in Hold; gain stops on RMS freeze, skew on either
	assign est_offset_en = engine_run;
	assign est_gain_en   = (state_q == ST_TRACK);
	assign est_skew_en   = (state_q == ST_TRACK) && !low_ac_power;
	// Gain adjustment only ever moves core 1 toward the reference core
	assign adj_offset_en = (state_q == ST_TRACK) && !ctl_q[`ICC_CTL_DIS_OFS];
	assign adj_gain_en   = (state_q == ST_TRACK) && !ctl_q[`ICC_CTL_DIS_GAIN];
	assign adj_skew_en   = (state_q == ST_TRACK) && !ctl_q[`ICC_CTL_DIS_SKEW] && !low_ac_power;

	// Status: bit 2 settled, bit 1 low AC power while running, bit 0 Hold
	assign status_byte = {5'h00, settled_q, low_ac_power && engine_run, state_q == ST_HOLD};

	// Register read data, one cycle after the read strobe
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `ICC_RESET_ZERO;
		end else if (rd_ok) begin
			case (reg_addr)
				`ICC_ADDR_POWER_MODE:     reg_rdata <= {5'h00, mode_q};
				`ICC_ADDR_C1_OFS_COARSE:  reg_rdata <= ofs_coarse_q;
				`ICC_ADDR_C1_OFS_FINE:    reg_rdata <= ofs_fine_q;
				`ICC_ADDR_C1_GAIN_COARSE: reg_rdata <= {4'h0, gain_coarse_q};
				`ICC_ADDR_C1_GAIN_MEDIUM: reg_rdata <= gain_medium_q;
				`ICC_ADDR_C1_GAIN_FINE:   reg_rdata <= gain_fine_q;
				`ICC_ADDR_STATUS:         reg_rdata <= status_byte;
				`ICC_ADDR_CONTROL:        reg_rdata <= ctl_q;
				`ICC_ADDR_STATIC_CONTROL: reg_rdata <= static_q;
				`ICC_ADDR_POWER_DOWN:     reg_rdata <= {6'h00, pd_q};
				`ICC_ADDR_RMS_THR_LOW:    reg_rdata <= thr_q[7:0];
				`ICC_ADDR_RMS_THR_HIGH:   reg_rdata <= thr_q[15:8];
				`ICC_ADDR_RMS_HYST:       reg_rdata <= hyst_q;
				default:                  reg_rdata <= `ICC_RESET_ZERO;
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== test/icc_host.sv ====
/*
 * Host model: register reads and writes with one-cycle strobes.
 * Assumes the clk of the control block and registered read data.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_host (
	input  wire logic       clk,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		// Released lines show the inverse of the last value
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge clk);
		#1;
		v = reg_rdata;
	endtask
	task automatic rmw(input logic [7:0] a, input logic [7:0] step);
		logic [7:0] v;
		rd(a, v);
		wr(a, v + step);
	endtask
	task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
		wr(hi, v[15:8]);
		wr(lo, v[7:0]);
	endtask
endmodule
`default_nettype wire

// ==== test/icc_ctrl_monitor.sv ====
/*
 * Port checker for the interleave correction control block.
 * Assumes one clock domain and the async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_mon (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       soft_reset,
	input wire logic [1:0] sleep_select_pin,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       port_enabled,
	input wire logic       low_ac_power,
	input wire logic       cal_done,
	input wire logic [2:0] power_state,
	input wire logic [7:0] trim_ofs_coarse,
	input wire logic       engine_run,
	input wire logic       est_offset_en,
	input wire logic       est_gain_en,
	input wire logic       est_skew_en,
	input wire logic       adj_offset_en,
	input wire logic       adj_gain_en,
	input wire logic       adj_skew_en,
	input wire logic       engine_starting
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_port_open: assert property ($rose(port_enabled) |-> $past(sleep_select_pin) == 2'h0)
		else $error("port enabled without normal pin");
	a_port_sticky: assert property (port_enabled |=> port_enabled)
		else $error("port enable dropped");
	a_mode_code: assert property (power_state inside {3'h1, 3'h2, 3'h4})
		else $error("illegal power state");
	a_start_pulse: assert property (engine_starting |=> !engine_starting)
		else $error("start pulse too long");
	a_est_needs_run: assert property ((est_offset_en || est_gain_en || est_skew_en) |-> engine_run)
		else $error("estimate active while engine stopped");
	a_adj_needs_run: assert property ((adj_offset_en || adj_gain_en || adj_skew_en) |-> engine_run)
		else $error("adjustment active while engine stopped");
	a_ac_skew_off: assert property ((low_ac_power && engine_run) |-> !est_skew_en)
		else $error("skew estimate runs at low ac power");
	a_trim_cause: assert property ($changed(trim_ofs_coarse) |->
		$past(reg_wr) || $past(soft_reset) || $past(cal_done))
		else $error("trim changed without cause");
	a_rdata_hold: assert property ($changed(reg_rdata) |-> $past(reg_rd))
		else $error("read data changed without read");
endmodule
bind icc_ctrl icc_mon i_mon (.clk, .reset_n, .soft_reset, .sleep_select_pin, .reg_wr, .reg_rd, .reg_rdata,
	.port_enabled, .low_ac_power, .cal_done, .power_state, .trim_ofs_coarse, .engine_run, .est_offset_en,
	.est_gain_en, .est_skew_en, .adj_offset_en, .adj_gain_en, .adj_skew_en, .engine_starting);
`default_nettype wire

// ==== test/tb_top.sv ====
/*
 * Testbench for the interleave correction control block.
 * Assumes the host model and checker files are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "icc_consts.vh"
module tb_top;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        soft_reset = 1'b0;
	logic [1:0]  pin = 2'h2;
	logic [13:0] sample = 14'h1000;
	logic        valid = 1'b1;
	logic        low_ac = 1'b0;
	logic [7:0]  cal = 8'h9C;
	logic        cal_done = 1'b0;
	logic [7:0]  d;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata, t_oc, t_gm;
	wire  [3:0]  t_gc;
	wire  [7:0]  t_of, t_gf;
	wire         start;
	wire  [2:0]  power_state;
	wire         reg_wr, reg_rd, port_en, run, est_o, est_g, est_s, adj_o, adj_g, adj_s, n_sel, n_pd, skip_c;
	int          num_errors = 0;
	int          check_count = 0;
	always #5 clk = ~clk;
	icc_ctrl #(.METER_CYCLES(8), .SETTLE_CYCLES(50)) i_dut (.clk(clk), .reset_n(reset_n),
		.soft_reset(soft_reset), .sleep_select_pin(pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_enabled(port_en),
		.sample(sample), .sample_valid(valid), .low_ac_power(low_ac), .cal_ofs_coarse(cal),
		.cal_ofs_fine(cal), .cal_gain_coarse(cal[3:0]), .cal_gain_medium(cal), .cal_gain_fine(cal),
		.cal_done(cal_done), .power_state(power_state), .trim_ofs_coarse(t_oc), .trim_ofs_fine(t_of),
		.trim_gain_coarse(t_gc), .trim_gain_medium(t_gm), .trim_gain_fine(t_gf), .engine_run(run),
		.est_offset_en(est_o), .est_gain_en(est_g), .est_skew_en(est_s), .adj_offset_en(adj_o),
		.adj_gain_en(adj_g), .adj_skew_en(adj_s), .notch_select(n_sel), .notch_power_down(n_pd),
		.skip_coarse(skip_c), .engine_starting(start));
	icc_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		stop_test;
	end
	initial begin
		cyc(3);
		reset_n = 1'b1;
		cal_done = 1'b1;
		i_host.wr(`ICC_ADDR_POWER_MODE, 8'h01);
		chk(port_en, 1'b0);
		chk(power_state, `ICC_MODE_SLEEP);
		rdc(`ICC_ADDR_POWER_MODE, 8'h00);
		pin = `ICC_PIN_NORMAL;
		cyc(2);
		chk(port_en, 1'b1);
		chk(power_state, `ICC_MODE_NORMAL);
		pin = `ICC_PIN_NAP;
		cyc(1);
		chk(power_state, `ICC_MODE_NAP);
		for (int i = 0; i < 3; i++) begin
			i_host.wr(`ICC_ADDR_POWER_MODE, 8'h01 << i);
			chk(power_state, 3'h1 << i);
		end
		i_host.wr16(`ICC_ADDR_RMS_THR_HIGH, `ICC_ADDR_RMS_THR_LOW, 16'h2234);
		rdc(`ICC_ADDR_RMS_THR_LOW, 8'h34);
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		rdc(`ICC_ADDR_POWER_MODE, 8'h04);
		rdc(`ICC_ADDR_RMS_THR_LOW, 8'h00);
		rdc(`ICC_ADDR_RMS_THR_HIGH, 8'h10);
		i_host.wr(`ICC_ADDR_POWER_MODE, 8'h00);
		chk(power_state, `ICC_MODE_NAP);
		pin = `ICC_PIN_NORMAL;
		$display("test power modes done");
		rdc(`ICC_ADDR_C1_OFS_COARSE, 8'h9C);
		i_host.rmw(`ICC_ADDR_C1_OFS_COARSE, 8'h01);
		chk(t_oc, 8'h9D);
		i_host.rmw(`ICC_ADDR_C1_OFS_COARSE, 8'hE3);
		chk(t_oc, 8'h80);
		i_host.wr(`ICC_ADDR_C1_OFS_FINE, 8'h7F);
		chk(t_of, 8'h7F);
		i_host.wr(`ICC_ADDR_C1_GAIN_COARSE, 8'hF3);
		chk(t_gc, 4'h3);
		rdc(`ICC_ADDR_C1_GAIN_COARSE, 8'h03);
		i_host.wr(`ICC_ADDR_C1_GAIN_MEDIUM, 8'hA5);
		chk(t_gm, 8'hA5);
		i_host.wr(`ICC_ADDR_C1_GAIN_FINE, 8'h5A);
		chk(t_gf, 8'h5A);
		$display("test trims done");
		i_host.wr(`ICC_ADDR_STATIC_CONTROL, 8'h61);
		rdc(`ICC_ADDR_STATIC_CONTROL, 8'h61);
		chk(skip_c, 1'b1);
		i_host.wr(`ICC_ADDR_POWER_DOWN, 8'h02);
		chk(n_pd, 1'b1);
		i_host.wr(`ICC_ADDR_CONTROL, 8'h21);
		chk(n_sel, 1'b1);
		cyc(1);
		chk(run, 1'b1);
		i_host.wr(`ICC_ADDR_POWER_DOWN, 8'h01);
		cyc(1);
		chk(run, 1'b0);
		i_host.wr(`ICC_ADDR_POWER_DOWN, 8'h00);
		cyc(2);
		chk(run, 1'b1);
		chk(start, 1'b1);
		rdc(`ICC_ADDR_STATUS, 8'h00);
		chk(start, 1'b0);
		$display("test engine control done");
		for (int i = 0; i < 3; i++) begin
			i_host.wr(`ICC_ADDR_CONTROL, 8'h01 | (8'h04 << i));
			chk({adj_s, adj_g, adj_o}, 3'h7 & ~(3'h1 << i));
		end
		i_host.wr(`ICC_ADDR_CONTROL, 8'h03);
		cyc(1);
		chk({run, est_s, est_g, est_o}, 4'h0);
		i_host.wr(`ICC_ADDR_CONTROL, 8'h01);
		cyc(1);
		chk({run, est_s, est_g, est_o}, 4'hF);
		cyc(60);
		i_host.wr(`ICC_ADDR_STATUS, 8'hFF);
		rdc(`ICC_ADDR_STATUS, 8'h04);
		$display("test freeze and settle done");
		i_host.wr(`ICC_ADDR_RMS_HYST, 8'hFF);
		sample = 14'h03FC;
		cyc(30);
		rdc(`ICC_ADDR_STATUS, 8'h05);
		chk({est_s, est_g, est_o}, 3'h1);
		sample = 14'h0400;
		cyc(30);
		rdc(`ICC_ADDR_STATUS, 8'h05);
		sample = 14'h0420;
		cyc(30);
		rdc(`ICC_ADDR_STATUS, 8'h04);
		low_ac = 1'b1;
		cyc(2);
		rdc(`ICC_ADDR_STATUS, 8'h06);
		chk({est_s, est_g, est_o}, 3'h3);
		low_ac = 1'b0;
		$display("test power meter done");
		stop_test;
	end
endmodule
`default_nettype wire
